// ===== pkg/usb_phy_params.svh
`ifndef USB_PHY_PARAMS_SVH
`define USB_PHY_PARAMS_SVH
// register byte offsets
`define OFS_POWER_SIGNAL   12'h03C
`define OFS_XCVR_CONTROL   12'h040
`define OFS_IRQ_STATUS     12'h044
`define OFS_IRQ_MASK       12'h048
`define OFS_LINE_STATUS    12'h04C
// power signalling fields
`define PWR_DATA_MSB       7
`define PWR_VALID_BIT      8
// transceiver control fields
`define CTL_PULLDOWN_OFF   18
`define CTL_WAKE_RESET     13
`define CTL_WAKE_RESUME    12
`define CTL_FILT_MSB       11
`define CTL_FILT_LSB       8
`define CTL_AUTO_RESUME    7
`define CTL_CONF_MSB       6
`define CTL_CONF_LSB       4
// writable masks and reset values
`define CTL_WRITE_MASK     32'h00043FF0
`define PWR_WRITE_MASK     32'h000001FF
`define CTL_RESET          32'h00000000
`define PWR_RESET          32'h00000000
// interrupt bits
`define IRQ_WAKE_RESET     0
`define IRQ_WAKE_RESUME    1
`define IRQ_LINE_CHANGE    2
`define IRQ_WIDTH          3
// widest filter exponent: 2**15 clocks
`define FILT_CNT_WIDTH     16
// synchroniser reset: suspend request low, line idle at j
`define SYNC_RESET         3'h1
`endif

// ===== pkg/usb_phy_pkg.sv
package usb_phy_pkg;
  // usb line states as seen by the transceiver
  typedef enum logic [1:0] {
    LINE_SE0 = 2'h0,
    LINE_J   = 2'h1,
    LINE_K   = 2'h2,
    LINE_SE1 = 2'h3
  } line_state_e;
  typedef enum {
    SUSP_IDLE,
    SUSP_ASLEEP,
    SUSP_WAKE
  } suspend_state_e;
endpackage

// ===== hdl/usb_line_sync.sv
`timescale 1ns/1ns
`include "usb_phy_params.svh"
// two-stage synchroniser for the raw line state and suspend pin
module usb_line_sync (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // asynchronous inputs
  input  wire logic [2:0] async_in,
  // synchronised outputs
  output logic      [2:0] sync_out
);
  logic [2:0] stage1;
  logic [2:0] next_stage1;
  logic [2:0] next_sync;

  // first stage feeds only the second stage
  always_comb begin
    next_stage1 = async_in;
    next_sync   = stage1;
  end

  // reset to the idle levels, or the filter would see a false se0 edge
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1   <= `SYNC_RESET;
      sync_out <= `SYNC_RESET;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync;
    end
  end
endmodule // usb_line_sync

// ===== hdl/usb_line_filter.sv
`timescale 1ns/1ns
`include "usb_phy_params.svh"
// holds off a line-state change until it has lasted 2**n clocks
module usb_line_filter
  import usb_phy_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // settings
  input  wire logic [3:0] log2_clocks,
  // line state
  input  wire logic [1:0] line_raw,
  output logic      [1:0] line_filt,
  output logic            changed
);
  logic [`FILT_CNT_WIDTH-1:0] count;
  logic [`FILT_CNT_WIDTH-1:0] next_count;
  logic [`FILT_CNT_WIDTH-1:0] target;
  logic [1:0]                 cand;
  logic [1:0]                 next_cand;
  logic [1:0]                 next_filt;
  logic                       next_changed;

  // a new value must repeat unbroken; k turning into se0 starts over,
  // so a short state squeezed between two others is never passed on
  always_comb begin
    target       = `FILT_CNT_WIDTH'(1) << log2_clocks;
    next_count   = '0;
    next_cand    = line_raw;
    next_filt    = line_filt;
    next_changed = 1'b0;
    if (line_raw != line_filt) begin
      if (line_raw == cand)
        next_count = count + `FILT_CNT_WIDTH'(1);
      else
        next_count = `FILT_CNT_WIDTH'(1);
      if (next_count >= target) begin
        next_filt    = line_raw;
        next_count   = '0;
        next_changed = 1'b1;
      end
    end
  end

  // the counter restarts on any glitch back to the old state
  always_ff @(posedge clk) begin
    if (srst) begin
      count     <= '0;
      cand      <= 2'h1;
      line_filt <= 2'h1;
      changed   <= 1'b0;
    end else begin
      count     <= next_count;
      cand      <= next_cand;
      line_filt <= next_filt;
      changed   <= next_changed;
    end
  end

  a_filter_holds: assert property (@(posedge clk) disable iff (srst)
    (line_raw == line_filt) |=> $stable(line_filt))
    else $error("filtered line moved while raw equalled it");
  a_filter_counts: assert property (@(posedge clk) disable iff (srst)
    $changed(line_filt) |-> (target == 1 || $past(line_raw) == line_filt))
    else $error("filter took a value the raw line did not show");
endmodule // usb_line_filter

// ===== hdl/usb_phy_resume_control.sv
`timescale 1ns/1ns
`include "usb_phy_params.svh"
module usb_phy_resume_control
  import usb_phy_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // transceiver side
  input  wire logic [1:0]  LINE_STATE,
  input  wire logic        SUSPEND_REQ,
  output logic      [2:0]  TRANSCEIVER_CONFIG_PINS,
  output logic             WIDE_PORT_FIRST_PULLDOWN_EN,
  output logic             WIDE_PORT_SECOND_PULLDOWN_EN,
  output logic             SUSPENDED,
  // power signalling
  output logic      [7:0]  POWER_DATA,
  output logic             POWER_VALID,
  // interrupt
  output logic             IRQ
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronise and filter the line
  logic [2:0] pins_sync;
  logic [1:0] line_filt;
  logic       line_changed;
  logic [31:0] ctl;
  logic [31:0] pwr;

  usb_line_sync u_sync (
    .clk      (CORE_CLK),
    .srst     (SRST),
    .async_in ({SUSPEND_REQ, LINE_STATE}),
    .sync_out (pins_sync)
  );

  usb_line_filter u_filter (
    .clk         (CORE_CLK),
    .srst        (SRST),
    .log2_clocks (ctl[`CTL_FILT_MSB:`CTL_FILT_LSB]),
    .line_raw    (pins_sync[1:0]),
    .line_filt   (line_filt),
    .changed     (line_changed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // suspend controller
  suspend_state_e susp;
  suspend_state_e next_susp;
  logic           wake_reset;
  logic           wake_resume;
  logic           next_wake_reset;
  logic           next_wake_resume;

  // with auto-resume on, only K or SE0 on the filtered line ends suspend; J is idle
  always_comb begin
    next_susp        = susp;
    next_wake_reset  = 1'b0;
    next_wake_resume = 1'b0;
    case (susp)
      SUSP_IDLE: begin
        if (pins_sync[2] && ctl[`CTL_AUTO_RESUME])
          next_susp = SUSP_ASLEEP;
      end
      SUSP_ASLEEP: begin
        if (!ctl[`CTL_AUTO_RESUME]) begin
          next_susp = SUSP_IDLE;
        end else if (line_filt == LINE_SE0) begin
          next_susp       = SUSP_WAKE;
          next_wake_reset = 1'b1;
        end else if (line_filt == LINE_K) begin
          next_susp        = SUSP_WAKE;
          next_wake_resume = 1'b1;
        end
      end
      SUSP_WAKE: begin
        // wait for the suspend request to drop before rearming
        if (!pins_sync[2])
          next_susp = SUSP_IDLE;
      end
      default: next_susp = SUSP_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      susp        <= SUSP_IDLE;
      wake_reset  <= 1'b0;
      wake_resume <= 1'b0;
    end else begin
      susp        <= next_susp;
      wake_reset  <= next_wake_reset;
      wake_resume <= next_wake_resume;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb register file
  logic [`IRQ_WIDTH-1:0] irq_status;
  logic [`IRQ_WIDTH-1:0] irq_mask;
  logic [31:0] next_ctl;
  logic [31:0] next_pwr;
  logic [`IRQ_WIDTH-1:0] next_irq_status;
  logic [`IRQ_WIDTH-1:0] next_irq_mask;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        access;
  logic        wr;
  logic        hit;
  logic [`IRQ_WIDTH-1:0] events;

  // one wait state: pready rises the cycle after the first access edge
  always_comb begin
    access = PSEL && PENABLE && !PREADY;
    wr     = access && PWRITE;
    events = '0;
    events[`IRQ_WAKE_RESET]  = wake_reset;
    events[`IRQ_WAKE_RESUME] = wake_resume;
    events[`IRQ_LINE_CHANGE] = line_changed;
    next_ctl        = ctl;
    next_pwr        = pwr;
    next_irq_mask   = irq_mask;
    next_irq_status = irq_status;
    next_prdata     = PRDATA;
    next_pready     = access;
    next_pslverr    = 1'b0;
    hit             = 1'b1;
    case (PADDR)
      `OFS_POWER_SIGNAL: begin
        next_prdata = pwr;
        if (wr)
          next_pwr = PWDATA & `PWR_WRITE_MASK;
      end
      `OFS_XCVR_CONTROL: begin
        next_prdata = ctl;
        if (wr)
          next_ctl = PWDATA & `CTL_WRITE_MASK;
      end
      `OFS_IRQ_STATUS: begin
        next_prdata = {{(32-`IRQ_WIDTH){1'b0}}, irq_status};
        if (wr)
          next_irq_status = irq_status & ~PWDATA[`IRQ_WIDTH-1:0];
      end
      `OFS_IRQ_MASK: begin
        next_prdata = {{(32-`IRQ_WIDTH){1'b0}}, irq_mask};
        if (wr)
          next_irq_mask = PWDATA[`IRQ_WIDTH-1:0];
      end
      `OFS_LINE_STATUS: begin
        // polled by software when auto-resume is off
        next_prdata = {29'h0, susp == SUSP_ASLEEP, line_filt};
      end
      default: begin
        hit         = 1'b0;
        next_prdata = 32'h0;
      end
    endcase
    if (access && !hit)
      next_pslverr = 1'b1;
    // hardware sets win over a software clear in the same cycle
    if (wake_reset)
      next_ctl[`CTL_WAKE_RESET] = 1'b1;
    if (wake_resume)
      next_ctl[`CTL_WAKE_RESUME] = 1'b1;
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctl        <= `CTL_RESET;
      pwr        <= `PWR_RESET;
      irq_status <= '0;
      irq_mask   <= '0;
      PRDATA     <= 32'h0;
      PREADY     <= 1'b0;
      PSLVERR    <= 1'b0;
    end else begin
      ctl        <= next_ctl;
      pwr        <= next_pwr;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      PRDATA     <= next_prdata;
      PREADY     <= next_pready;
      PSLVERR    <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs toward the transceiver, power logic and interrupt line
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      TRANSCEIVER_CONFIG_PINS      <= 3'h0;
      WIDE_PORT_FIRST_PULLDOWN_EN  <= 1'b1;
      WIDE_PORT_SECOND_PULLDOWN_EN <= 1'b1;
      SUSPENDED                    <= 1'b0;
      POWER_DATA                   <= 8'h0;
      POWER_VALID                  <= 1'b0;
      IRQ                          <= 1'b0;
    end else begin
      TRANSCEIVER_CONFIG_PINS <= ctl[`CTL_CONF_MSB:`CTL_CONF_LSB];
      WIDE_PORT_FIRST_PULLDOWN_EN  <= !ctl[`CTL_PULLDOWN_OFF];
      WIDE_PORT_SECOND_PULLDOWN_EN <= !ctl[`CTL_PULLDOWN_OFF];
      SUSPENDED   <= (susp == SUSP_ASLEEP);
      POWER_DATA  <= pwr[`PWR_DATA_MSB:0];
      POWER_VALID <= pwr[`PWR_VALID_BIT];
      IRQ         <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_pulldown_follows: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    ##1 (WIDE_PORT_FIRST_PULLDOWN_EN == !$past(ctl[`CTL_PULLDOWN_OFF]))
    && (WIDE_PORT_SECOND_PULLDOWN_EN == WIDE_PORT_FIRST_PULLDOWN_EN))
    else $error("pulldown enable does not follow control bit");
  a_wake_reset_flag: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    wake_reset |=> ctl[`CTL_WAKE_RESET])
    else $error("reset wake flag not set");
  a_wake_resume_flag: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    wake_resume |=> ctl[`CTL_WAKE_RESUME])
    else $error("resume wake flag not set");
  // the flags only fall through a register write
  a_flag_sticky: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    (ctl[`CTL_WAKE_RESET] && !wr) |=> ctl[`CTL_WAKE_RESET])
    else $error("reset wake flag dropped without a write");
  a_resume_sticky: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    (ctl[`CTL_WAKE_RESUME] && !wr) |=> ctl[`CTL_WAKE_RESUME])
    else $error("resume wake flag dropped without a write");
  a_wake_irq: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    wake_reset |=> irq_status[`IRQ_WAKE_RESET])
    else $error("reset wake left no interrupt status");
  a_wake_needs_auto: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    (wake_reset || wake_resume) |-> $past(ctl[`CTL_AUTO_RESUME]))
    else $error("wake raised with auto resume off");
  a_sleep_entry: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    (susp == SUSP_IDLE && pins_sync[2] && ctl[`CTL_AUTO_RESUME])
    |=> susp == SUSP_ASLEEP)
    else $error("suspend request with auto resume did not sleep");
  a_asleep_se0_wakes: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    (susp == SUSP_ASLEEP && ctl[`CTL_AUTO_RESUME] && line_filt == LINE_SE0)
    |=> wake_reset ##1 SUSPENDED == 1'b0)
    else $error("se0 during suspend did not wake");
  a_asleep_k_wakes: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    (susp == SUSP_ASLEEP && ctl[`CTL_AUTO_RESUME] && line_filt == LINE_K)
    |=> wake_resume ##1 SUSPENDED == 1'b0)
    else $error("k during suspend did not wake");
  // with auto resume off software polls, so no flag may rise
  a_manual_no_wake: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    (susp == SUSP_ASLEEP && !ctl[`CTL_AUTO_RESUME])
    |=> susp == SUSP_IDLE && !wake_reset && !wake_resume)
    else $error("suspend held or woke with auto resume off");
  a_config_pins: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    $changed(ctl[`CTL_CONF_MSB:`CTL_CONF_LSB]) |=>
    TRANSCEIVER_CONFIG_PINS == $past(ctl[`CTL_CONF_MSB:`CTL_CONF_LSB]))
    else $error("config pins do not follow field");
  a_power_valid: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    ##1 (pwr[31:9] == 23'h0) && POWER_VALID == $past(pwr[8]))
    else $error("power word reserved bits or valid flag wrong");
  a_power_data: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    1'b1 |=> POWER_DATA == $past(pwr[`PWR_DATA_MSB:0]))
    else $error("power data pins do not follow register");
  a_ctl_reserved: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    (ctl & ~`CTL_WRITE_MASK) == 32'h0)
    else $error("control register reserved bits set");
  // one-cycle answer; an error only ever rides with ready
  a_pready_pulse: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    PREADY |=> !PREADY)
    else $error("ready held for more than one cycle");
  a_pslverr_ready: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    PSLVERR |-> PREADY)
    else $error("slave error without ready");
  a_irq_level: assert property (
    @(posedge CORE_CLK) disable iff (SRST)
    1'b1 |=> IRQ == (|$past(irq_status & irq_mask)))
    else $error("interrupt output does not follow status and mask");
endmodule // usb_phy_resume_control

// ===== verif/usb_xcvr_model.sv
`timescale 1ns/1ns
// transceiver stand-in: line state and bus-idle level, relaunched
// just after each edge so the design sees them as async inputs
module usb_xcvr_model
  import usb_phy_pkg::*;
(
  // clock
  input  wire logic       clk,
  // bench commands
  input  wire logic [1:0] want_line,
  input  wire logic       want_susp,
  // transceiver pins
  input  wire logic [2:0] conf_pins,
  output logic      [1:0] line_state,
  output logic            susp_req,
  output logic      [2:0] conf_seen
);
  // idle bus shows j, never an unknown
  initial begin
    line_state = LINE_J;
    susp_req   = 1'b0;
    conf_seen  = 3'h0;
  end
  // pins latched as the far side would see them
  always @(posedge clk) begin
    line_state <= want_line;
    susp_req   <= want_susp;
    conf_seen  <= conf_pins;
  end
endmodule // usb_xcvr_model

// ===== verif/usb_phy_resume_control_test.sv
`timescale 1ns/1ns
`include "usb_phy_params.svh"
module usb_phy_resume_control_test
  import usb_phy_pkg::*;
  ;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [1:0]  want_line = LINE_J;
  logic        want_susp = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, susp, irq, pv, pd1, pd2, sreq;
  logic [2:0]  conf, conf_seen;
  logic [1:0]  line;
  logic [7:0]  pdata;
  int          mismatches = 0;
  int          checked = 0;
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  usb_phy_resume_control dut_u (
    .CORE_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINE_STATE(line),
    .SUSPEND_REQ(sreq), .TRANSCEIVER_CONFIG_PINS(conf),
    .WIDE_PORT_FIRST_PULLDOWN_EN(pd1),
    .WIDE_PORT_SECOND_PULLDOWN_EN(pd2), .SUSPENDED(susp),
    .POWER_DATA(pdata), .POWER_VALID(pv), .IRQ(irq));
  usb_xcvr_model xcvr_u (
    .clk(clk), .want_line(want_line), .want_susp(want_susp),
    .conf_pins(conf), .line_state(line), .susp_req(sreq),
    .conf_seen(conf_seen));
  ////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n == 20) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
    input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`OFS_POWER_SIGNAL, 32'h0, "pwr rst");
    rd(`OFS_XCVR_CONTROL, 32'h0, "ctl rst");
    chk("pulldowns", 32'h3, {30'h0, pd1, pd2});
    chk("conf", 32'h0, {29'h0, conf});
  endtask
  // data and valid move apart; reserved bits stay zero
  task automatic t_power();
    wr(`OFS_POWER_SIGNAL, 32'hFFFFFFFF);
    rd(`OFS_POWER_SIGNAL, 32'h1FF, "pwr all");
    chk("pwr pins", 32'h1FF, {23'h0, pv, pdata});
    wr(`OFS_POWER_SIGNAL, 32'hFFFFFEA5);
    rd(`OFS_POWER_SIGNAL, 32'hA5, "pwr data");
    chk("pwr pins", 32'hA5, {23'h0, pv, pdata});
  endtask
  task automatic t_ctl();
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_XCVR_CONTROL, 32'h40000 | (i << 4));
      repeat (2) @(posedge clk);
      chk("conf", i, {29'h0, conf_seen});
      chk("pd off", 32'h0, {30'h0, pd1, pd2});
    end
    wr(`OFS_XCVR_CONTROL, 32'hFFFF0F0F);
    rd(`OFS_XCVR_CONTROL, 32'h00040F00, "ctl mask");
    wr(`OFS_XCVR_CONTROL, 32'h0);
    repeat (2) @(posedge clk);
    chk("pd on", 32'h3, {30'h0, pd1, pd2});
    apb(1'b0, 12'h050, 32'h0, r, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, r);
  endtask
  // n=2: three-clock glitch held off, longer k propagates
  task automatic t_filter();
    wr(`OFS_XCVR_CONTROL, 32'h200);
    want_line <= LINE_K;
    repeat (3) @(posedge clk);
    want_line <= LINE_J;
    repeat (12) @(posedge clk);
    rd(`OFS_LINE_STATUS, 32'h1, "glitch");
    rd(`OFS_IRQ_STATUS, 32'h0, "no chg");
    want_line <= LINE_K;
    repeat (12) @(posedge clk);
    rd(`OFS_LINE_STATUS, 32'h2, "held k");
    rd(`OFS_XCVR_CONTROL, 32'h200, "no auto");
    rd(`OFS_IRQ_STATUS, 32'h4, "chg irq");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`OFS_IRQ_MASK, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`OFS_IRQ_STATUS, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq clr", 32'h0, {31'h0, irq});
    want_line <= LINE_J;
    repeat (12) @(posedge clk);
    wr(`OFS_IRQ_STATUS, 32'h7);
  endtask
  // reset in mid-run with the pins moved off their reset levels
  task automatic t_rerst();
    wr(`OFS_XCVR_CONTROL, 32'h40070);
    wr(`OFS_POWER_SIGNAL, 32'h1A5);
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    chk("pwr pins rst", 32'h0, {23'h0, pv, pdata});
    chk("irq rst", 32'h0, {31'h0, irq});
    chk("susp rst", 32'h0, {31'h0, susp});
  endtask
  // auto-resume by k then by se0, flags cleared by writing zero
  task automatic t_wake();
    for (int i = 0; i < 2; i++) begin
      wr(`OFS_XCVR_CONTROL, 32'h80);
      want_susp <= 1'b1;
      repeat (6) @(posedge clk);
      chk("asleep", 32'h1, {31'h0, susp});
      want_line <= (i == 1) ? LINE_SE0 : LINE_K;
      repeat (8) @(posedge clk);
      rd(`OFS_XCVR_CONTROL, (i == 1) ? 32'h2080 : 32'h1080, "wake");
      rd(`OFS_IRQ_STATUS, (i == 1) ? 32'h5 : 32'h6, "wake irq");
      want_susp <= 1'b0;
      want_line <= LINE_J;
      repeat (8) @(posedge clk);
      chk("awake", 32'h0, {31'h0, susp});
      rd(`OFS_XCVR_CONTROL, (i == 1) ? 32'h2080 : 32'h1080, "sticky");
      wr(`OFS_XCVR_CONTROL, 32'h0);
      rd(`OFS_XCVR_CONTROL, 32'h0, "flag clr");
      wr(`OFS_IRQ_STATUS, 32'h7);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_power();
    t_ctl();
    t_filter();
    t_rerst();
    t_wake();
    finish_test();
  end
endmodule // usb_phy_resume_control_test
